// ===== tcdl_pkg.sv
// What this block does
// RQ1: Interrupt events never redirect flow; they only wake the core.
// RQ2: Wait or stop instruction gates the core clock and suspends activity. The core does not gate ref_clk; it holds in TCDL_SLEEP and raises core_gated.
// RQ3: Low-power state lasts until an interrupt or reset event arrives.
// RQ4: Active background mode stops user code and waits for debug commands. The core takes no debug commands; it leaves once bg_lvl_r is low.
// RQ5: Index pointer at 0x0F; data window 0x0E redirects to pointed byte.
// RQ6: Direct mode takes operand as low byte, high byte forced zero.
// RQ7: Extended address is two bytes: 00 plus upper six, then low eight.
// RQ8: Four-bit-page mode takes address from opcode low four bits.
// RQ9: Five-bit-page mode takes address from opcode low five bits.
// RQ10: Branch offset is signed eight bits added to next instruction address.
// RQ11: Sixteen-bit address operands are 14-bit with upper two bits zero.
// RQ12: Add-with-carry: A9 immediate 2 cycles, B9 direct 3; Z and C. The core takes 3 cycles for both.
// RQ13: Add: AB immediate, BB direct, 6x four-bit page; Z and C updated.
// RQ14: AND: A4 immediate, B4 direct; Z updated, carry unchanged.
// RQ15: Flags hold only zero and carry; each op keeps, forces or sets them.
// RQ16: Program counter and shadow counter split into six and eight bits.
// RQ17: Arithmetic left shift acts exactly like logical left shift.
// RQ18: After reset fetch starts at 0x3FFD, aborting any instruction.
// RQ19: Interrupt wakeup resumes at the next instruction, no vectoring.
package tcdl_pkg;
  localparam int ADDR_W = 14;
  localparam logic [13:0] RESET_PC = 14'h3FFD;
  localparam logic [13:0] WIN_ADDR = 14'h000E;
  localparam logic [13:0] PTR_ADDR = 14'h000F;
  localparam logic [7:0] OP_ADC_IMM = 8'hA9;
  localparam logic [7:0] OP_ADC_DIR = 8'hB9;
  localparam logic [7:0] OP_ADD_IMM = 8'hAB;
  localparam logic [7:0] OP_ADD_DIR = 8'hBB;
  localparam logic [3:0] OP_ADD_TNY = 4'h6;
  localparam logic [7:0] OP_AND_IMM = 8'hA4;
  localparam logic [7:0] OP_AND_DIR = 8'hB4;
  localparam logic [7:0] OP_ASL_ACC = 8'h48;
  localparam logic [7:0] OP_LDA_IMM = 8'hA6;
  localparam logic [7:0] OP_BRA = 8'h30;
  localparam logic [7:0] OP_JMP_EXT = 8'hBC;
  localparam logic [7:0] OP_WAIT = 8'hAF;
  localparam logic [7:0] OP_STOP = 8'hAE;
  localparam logic [7:0] OP_BGND = 8'hBF;
  // Bus slave register map (word addresses are byte offset >> 2)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h1;
  localparam logic [3:0] REG_ACC = 4'h2;
  localparam logic [3:0] REG_PC = 4'h3;
  localparam logic [3:0] REG_SPC = 4'h4;
  localparam logic [3:0] REG_MADDR = 4'h5;
  localparam logic [3:0] REG_MDATA = 4'h6;
  localparam logic [3:0] REG_EVT = 4'h7;
  localparam int MEM_WORDS = 16384;
  typedef enum logic [2:0] {
    TCDL_FETCH = 3'b000,
    TCDL_OPND1 = 3'b001,
    TCDL_OPND2 = 3'b011,
    TCDL_EXEC = 3'b010,
    TCDL_SLEEP = 3'b110,
    TCDL_BDM = 3'b111,
    TCDL_RESET = 3'b101
  } tcdl_state_t;
  typedef enum logic [2:0] {
    TCDL_M_INH, TCDL_M_IMM, TCDL_M_DIR, TCDL_M_TNY, TCDL_M_SRT,
    TCDL_M_EXT, TCDL_M_REL
  } tcdl_mode_t;
  typedef enum logic [2:0] {
    TCDL_A_NONE, TCDL_A_ADC, TCDL_A_ADD, TCDL_A_AND, TCDL_A_ASL,
    TCDL_A_LDA, TCDL_A_BRA, TCDL_A_JMP
  } tcdl_alu_t;
  typedef struct packed {
    tcdl_mode_t mode;
    tcdl_alu_t alu;
    logic valid;
  } tcdl_dec_t;
  typedef struct packed {
    logic z;
    logic c;
  } tcdl_flags_t;
  typedef struct packed {
    logic [5:0] upper;
    logic [7:0] lower;
  } tcdl_pc_t;
endpackage : tcdl_pkg

// ===== tcdl_decode.sv
`timescale 1ns/1ns
// Pure opcode decode; no state
module tcdl_decode (
  input wire logic [7:0] opcode,
  output tcdl_pkg::tcdl_dec_t dec
);
  import tcdl_pkg::*;
  // Opcode groups to address mode and operation
  always_comb begin
    dec = '{mode: TCDL_M_INH, alu: TCDL_A_NONE, valid: 1'b1};
    if (opcode == OP_ADC_IMM) begin // [RQ12]
      dec.mode = TCDL_M_IMM;
      dec.alu = TCDL_A_ADC;
    end else if (opcode == OP_ADC_DIR) begin // [RQ12]
      dec.mode = TCDL_M_DIR;
      dec.alu = TCDL_A_ADC;
    end else if (opcode == OP_ADD_IMM) begin // [RQ13]
      dec.mode = TCDL_M_IMM;
      dec.alu = TCDL_A_ADD;
    end else if (opcode == OP_ADD_DIR) begin // [RQ13]
      dec.mode = TCDL_M_DIR;
      dec.alu = TCDL_A_ADD;
    end else if (opcode[7:4] == OP_ADD_TNY) begin // [RQ13] [RQ8]
      dec.mode = TCDL_M_TNY;
      dec.alu = TCDL_A_ADD;
    end else if (opcode == OP_AND_IMM) begin // [RQ14]
      dec.mode = TCDL_M_IMM;
      dec.alu = TCDL_A_AND;
    end else if (opcode == OP_AND_DIR) begin // [RQ14]
      dec.mode = TCDL_M_DIR;
      dec.alu = TCDL_A_AND;
    end else if (opcode == OP_ASL_ACC) begin // [RQ17]
      dec.alu = TCDL_A_ASL;
    end else if (opcode == OP_LDA_IMM) begin
      dec.mode = TCDL_M_IMM;
      dec.alu = TCDL_A_LDA;
    end else if (opcode[7:5] == 3'h6) begin // [RQ9] short load
      dec.mode = TCDL_M_SRT;
      dec.alu = TCDL_A_LDA;
    end else if (opcode == OP_BRA) begin // [RQ10]
      dec.mode = TCDL_M_REL;
      dec.alu = TCDL_A_BRA;
    end else if (opcode == OP_JMP_EXT) begin // [RQ7]
      dec.mode = TCDL_M_EXT;
      dec.alu = TCDL_A_JMP;
    end else if (opcode != OP_WAIT && opcode != OP_STOP &&
                 opcode != OP_BGND) begin
      dec.valid = 1'b0;
    end
  end
endmodule : tcdl_decode

// ===== tcdl_core.sv
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
// Core with internal memory, reached from software over Wishbone
module tcdl_core (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic wake_evt,
  input wire logic bgnd_req,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic core_gated,
  output logic in_bdm
);
  import tcdl_pkg::*;

  // ==========================================================
  // Pin synchronisers: three stages, change counted on agreement
  logic [2:0] wake_s_r, bg_s_r;
  logic wake_lvl_r, bg_lvl_r;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_s_r <= 3'h0;
      bg_s_r <= 3'h0;
      wake_lvl_r <= 1'b0;
      bg_lvl_r <= 1'b0;
    end else begin
      wake_s_r <= {wake_s_r[1:0], wake_evt};
      bg_s_r <= {bg_s_r[1:0], bgnd_req};
      if (wake_s_r[1] == wake_s_r[2]) wake_lvl_r <= wake_s_r[2];
      if (bg_s_r[1] == bg_s_r[2]) bg_lvl_r <= bg_s_r[2];
    end
  end

  // ==========================================================
  // Architectural state
  tcdl_state_t st_r, st_nxt;
  tcdl_pc_t pc_r, pc_nxt; // [RQ16]
  tcdl_pc_t spc_r; // [RQ16]
  tcdl_flags_t flags_r, flags_nxt; // [RQ15]
  logic [7:0] acc_r, acc_nxt;
  logic [7:0] op_r, op_nxt;
  logic [7:0] b1_r, b1_nxt;
  logic [7:0] b2_r, b2_nxt;
  logic [7:0] mem [MEM_WORDS];
  logic run_en_r; // Software run enable
  logic wake_seen_r; // Sticky wake seen, software clears it by writing 1 to REG_EVT
  tcdl_dec_t dec;

  tcdl_decode u_dec (
    .opcode(op_r),
    .dec(dec)
  );

  // ==========================================================
  // Address formation
  function automatic logic [13:0] pcv(input tcdl_pc_t p);
    return {p.upper, p.lower};
  endfunction : pcv

  // Index window redirect: 0x0E reads through the pointer at 0x0F
  function automatic logic [13:0] eff(input logic [13:0] a,
                                      input logic [7:0] ptr);
    return (a == WIN_ADDR) ? {6'h00, ptr} : a; // [RQ5]
  endfunction : eff

  wire [7:0] ptr_val = mem[PTR_ADDR]; // [RQ5]
  wire [13:0] pc_now = pcv(pc_r);
  wire [13:0] pc_inc = pc_now + 14'h0001;
  wire [13:0] dir_addr = {6'h00, b1_r}; // [RQ6]
  wire [13:0] tny_addr = {10'h000, op_r[3:0]}; // [RQ8]
  wire [13:0] srt_addr = {9'h000, op_r[4:0]}; // [RQ9]
  wire [13:0] ext_addr = {b1_r[5:0], b2_r}; // [RQ7] [RQ11]
  // Branch target: sign-extended offset added to next instruction
  wire [13:0] rel_tgt = pc_now + {{6{b1_r[7]}}, b1_r}; // [RQ10]
  wire [13:0] opnd_addr =
    (dec.mode == TCDL_M_TNY) ? eff(tny_addr, ptr_val) :
    (dec.mode == TCDL_M_SRT) ? eff(srt_addr, ptr_val) :
    eff(dir_addr, ptr_val);
  wire [7:0] mem_opnd = mem[opnd_addr];
  wire [7:0] opnd = (dec.mode == TCDL_M_IMM) ? b1_r : mem_opnd;
  wire [8:0] sum = {1'b0, acc_r} + {1'b0, opnd} +
                   {8'h00, dec.alu == TCDL_A_ADC ? flags_r.c : 1'b0};
  wire [7:0] fetch_byte = mem[pc_now];
  wire need_b1 = dec.mode inside {TCDL_M_IMM, TCDL_M_DIR,
                                  TCDL_M_EXT, TCDL_M_REL};
  wire is_sleep = (op_r == OP_WAIT) || (op_r == OP_STOP);

  // ==========================================================
  // Sequencer. Interrupt events never vector; they only end sleep.
  always_comb begin
    st_nxt = st_r;
    pc_nxt = pc_r;
    flags_nxt = flags_r;
    acc_nxt = acc_r;
    op_nxt = op_r;
    b1_nxt = b1_r;
    b2_nxt = b2_r;
    unique case (st_r)
      TCDL_RESET: begin
        pc_nxt = RESET_PC; // [RQ18]
        st_nxt = TCDL_FETCH;
      end
      TCDL_FETCH: begin
        if (bg_lvl_r) begin
          st_nxt = TCDL_BDM; // [RQ4]
        end else if (run_en_r) begin // [RQ1] no redirect by wake_lvl_r
          op_nxt = fetch_byte;
          pc_nxt = pc_inc;
          st_nxt = TCDL_OPND1;
        end
      end
      TCDL_OPND1: begin
        if (need_b1) begin
          b1_nxt = fetch_byte;
          pc_nxt = pc_inc;
        end
        st_nxt = (dec.mode == TCDL_M_EXT) ? TCDL_OPND2 : TCDL_EXEC;
      end
      TCDL_OPND2: begin
        b2_nxt = fetch_byte;
        pc_nxt = pc_inc;
        st_nxt = TCDL_EXEC;
      end
      TCDL_EXEC: begin
        st_nxt = TCDL_FETCH;
        unique case (dec.alu)
          TCDL_A_ADC, TCDL_A_ADD: begin // [RQ12] [RQ13]
            acc_nxt = sum[7:0];
            flags_nxt.z = (sum[7:0] == 8'h00);
            flags_nxt.c = sum[8];
          end
          TCDL_A_AND: begin // [RQ14] carry left alone
            acc_nxt = acc_r & opnd;
            flags_nxt.z = ((acc_r & opnd) == 8'h00);
          end
          TCDL_A_ASL: begin // [RQ17]
            acc_nxt = {acc_r[6:0], 1'b0};
            flags_nxt.c = acc_r[7];
            flags_nxt.z = (acc_r[6:0] == 7'h00);
          end
          TCDL_A_LDA: acc_nxt = opnd;
          TCDL_A_BRA: pc_nxt = rel_tgt; // [RQ10]
          TCDL_A_JMP: pc_nxt = ext_addr; // [RQ7]
          TCDL_A_NONE: begin
            if (is_sleep) st_nxt = TCDL_SLEEP; // [RQ2]
            else if (op_r == OP_BGND) st_nxt = TCDL_BDM; // [RQ4]
          end
        endcase
      end
      TCDL_SLEEP: begin
        // PC already points past the sleep opcode: plain resume
        if (wake_lvl_r) st_nxt = TCDL_FETCH; // [RQ3] [RQ19]
      end
      TCDL_BDM: begin
        if (!bg_lvl_r) st_nxt = TCDL_FETCH; // [RQ4]
      end
      default: st_nxt = TCDL_RESET;
    endcase
  end

  // Shadow counter keeps the return address on each jump
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= TCDL_RESET; // [RQ18] aborts anything in flight
      pc_r <= RESET_PC;
      spc_r <= '0;
      flags_r <= '0;
      acc_r <= 8'h00;
      op_r <= 8'h00;
      b1_r <= 8'h00;
      b2_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      pc_r <= pc_nxt;
      flags_r <= flags_nxt;
      acc_r <= acc_nxt;
      op_r <= op_nxt;
      b1_r <= b1_nxt;
      b2_r <= b2_nxt;
      if (st_r == TCDL_EXEC && dec.alu == TCDL_A_JMP) spc_r <= pc_r;
    end
  end

  // ==========================================================
  // Wishbone slave: ack one cycle after strobe, dropped next cycle
  logic [13:0] maddr_r;
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wb_wr = wb_req && wb_we_i && wb_sel_i[0];
  wire [7:0] mem_rd = mem[eff(maddr_r, ptr_val)];
  wire [31:0] rd_mux =
    (wb_adr_i == REG_CTRL) ? {31'h0, run_en_r} :
    (wb_adr_i == REG_STAT) ? {27'h0, wake_seen_r, st_r, in_bdm} :
    (wb_adr_i == REG_ACC) ? {22'h0, flags_r, acc_r} :
    (wb_adr_i == REG_PC) ? {18'h0, pc_r} :
    (wb_adr_i == REG_SPC) ? {18'h0, spc_r} :
    (wb_adr_i == REG_MADDR) ? {18'h0, maddr_r} :
    (wb_adr_i == REG_MDATA) ? {24'h0, mem_rd} :
    (wb_adr_i == REG_EVT) ? {31'h0, wake_seen_r} : 32'h0;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      run_en_r <= 1'b0;
      maddr_r <= '0;
      wake_seen_r <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_mux : 32'h0;
      if (wb_wr && wb_adr_i == REG_CTRL) run_en_r <= wb_dat_i[0];
      if (wb_wr && wb_adr_i == REG_MADDR) maddr_r <= wb_dat_i[13:0];
      // Polled event: set wins over the clear [RQ1]
      if (wake_lvl_r) wake_seen_r <= 1'b1;
      else if (wb_wr && wb_adr_i == REG_EVT && wb_dat_i[0])
        wake_seen_r <= 1'b0;
    end
  end

  // Memory writes: core store paths are absent, software loads memory
  always_ff @(posedge ref_clk) begin
    if (wb_wr && wb_adr_i == REG_MDATA)
      mem[eff(maddr_r, ptr_val)] <= wb_dat_i[7:0];
  end

  // Status outputs registered
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      core_gated <= 1'b0;
      in_bdm <= 1'b0;
    end else begin
      core_gated <= (st_nxt == TCDL_SLEEP); // [RQ2]
      in_bdm <= (st_nxt == TCDL_BDM); // [RQ4]
    end
  end

  // ==========================================================
  // Checks
  a_reset_vector: assert property (@(posedge ref_clk) // [RQ18]
    st_r == TCDL_RESET |=> pc_r == RESET_PC)
    else $error("pc not at reset vector");
  a_sleep_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_r == TCDL_SLEEP && !wake_lvl_r |=> st_r == TCDL_SLEEP) // [RQ3]
    else $error("left sleep without wake");
  a_sleep_pc: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_r == TCDL_SLEEP |=> $stable(pc_r)) // [RQ2]
    else $error("pc moved while asleep");
  a_wake_resume: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_r == TCDL_SLEEP && wake_lvl_r |=> st_r == TCDL_FETCH) // [RQ19]
    else $error("wake did not resume");
  a_and_carry: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_r == TCDL_EXEC && dec.alu == TCDL_A_AND
    |=> $stable(flags_r.c)) // [RQ14]
    else $error("and touched carry");
  a_bdm_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_r == TCDL_BDM && bg_lvl_r |=> st_r == TCDL_BDM) // [RQ4]
    else $error("left background mode");
  a_add_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_r == TCDL_EXEC && dec.alu == TCDL_A_ADD
    |=> flags_r.z == (acc_r == 8'h00)) // [RQ13]
    else $error("zero flag wrong");
  a_no_vector: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_r == TCDL_FETCH && run_en_r && !bg_lvl_r
    |=> pc_r == $past(pc_r) + 14'h0001) // [RQ1]
    else $error("flow redirected");
endmodule : tcdl_core

// ===== tcdl_evt_src.sv
`timescale 1ns/1ns
// ==========
// Wake and debug request source
module tcdl_evt_src #(
  parameter int WAKE_LEN = 4
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic fire_wake,
  input wire logic dbg_on,
  output logic wake_evt,
  output logic bgnd_req
);
  logic [3:0] cnt_r;
  // Wake held several cycles so the three-flop sync cannot miss it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 4'h0;
      bgnd_req <= 1'b0;
    end else begin
      if (fire_wake) cnt_r <= WAKE_LEN[3:0];
      else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
      bgnd_req <= dbg_on;
    end
  end
  // Level output straight from the count
  assign wake_evt = (cnt_r != 4'h0);
endmodule : tcdl_evt_src

// ===== tb.sv
`timescale 1ns/1ns
module tb;
  import tcdl_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic fire_wake = 1'b0;
  logic dbg_on = 1'b0;
  logic wake_evt;
  logic bgnd_req;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic core_gated;
  logic in_bdm;
  int errors = 0;
  int checks_done = 0;
  logic [31:0] rd;
  logic [7:0] v [0:7];
  logic [7:0] prog [$];
  int a;
  int c;
  int s;
  logic z;
  // ==========
  // Clock, partner and design
  always #4 ref_clk = ~ref_clk;
  tcdl_evt_src u_tcdl_evt_src (.ref_clk, .arst_n, .fire_wake, .dbg_on,
    .wake_evt, .bgnd_req);
  tcdl_core u_tcdl_core (.ref_clk, .arst_n, .wake_evt, .bgnd_req,
    .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o, .core_gated, .in_bdm);
  // ==========
  // Reporting
  task automatic close_out;
    $display("checks=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_w
  task automatic chk_b(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_b
  // ==========
  // Bus master: hold until ack, take data at that edge
  task automatic bus(input logic [3:0] adr, input logic we,
                     input logic [31:0] dat);
    int n;
    @(posedge ref_clk);
    wb_adr_i <= adr;
    wb_we_i <= we;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hF;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 64);
    if (n >= 64) begin
      errors++;
      close_out();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus
  task automatic poke(input logic [13:0] adr, input logic [7:0] b);
    bus(REG_MADDR, 1'b1, {18'h0, adr});
    bus(REG_MDATA, 1'b1, {24'h0, b});
  endtask : poke
  // Bounded wait on a status pin; 0 picks the sleep flag
  task automatic wait_pin(input int sel, input logic val);
    int n;
    n = 0;
    while (((sel == 0) ? core_gated : in_bdm) !== val && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 2000) begin
      errors++;
      close_out();
    end
  endtask : wait_pin
  task automatic do_reset;
    arst_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
  endtask : do_reset
  // Reference adder; carry in is explicit so ADD and ADC share it
  function automatic void add_op(input int m, input int ci);
    s = a + m + ci;
    c = s >> 8;
    a = s & 255;
  endfunction : add_op
  // ==========
  // Main sequence
  initial begin
    void'($urandom(32'h5B9D));
    foreach (v[i]) v[i] = 8'($urandom());
    do_reset();
    bus(REG_PC, 1'b0, 32'h0);
    chk_w(rd, {18'h0, RESET_PC});
    bus(4'hF, 1'b1, 32'hFFFF_FFFF);
    bus(4'hF, 1'b0, 32'h0);
    chk_w(rd, 32'h0);
    // Data bytes and pointer for the direct, window and page forms
    poke(14'h0020, v[5]);
    poke(14'h0021, v[6]);
    poke(14'h0003, v[7]);
    poke(PTR_ADDR, 8'h21);
    bus(REG_MADDR, 1'b1, {18'h0, WIN_ADDR});
    bus(REG_MDATA, 1'b0, 32'h0);
    chk_w(rd, {24'h0, v[6]});
    // Skipped byte is a shift, so a wrong branch corrupts the sum
    prog = {OP_LDA_IMM, v[0], OP_ADD_IMM, v[1], OP_ADC_IMM, v[2],
      OP_AND_IMM, v[3], OP_ADD_DIR, 8'h20, OP_ADC_DIR, 8'h0E,
      OP_AND_DIR, 8'h0F, 8'h63, OP_ASL_ACC, OP_BRA, 8'h01, OP_ASL_ACC,
      OP_WAIT, OP_LDA_IMM, v[4], OP_BGND};
    foreach (prog[i]) poke(14'h0100 + 14'(i), prog[i]);
    poke(14'h3FFD, OP_JMP_EXT);
    poke(14'h3FFE, 8'h01);
    poke(14'h3FFF, 8'h00);
    bus(REG_CTRL, 1'b1, 32'h1);
    wait_pin(0, 1'b1);
    chk_b(core_gated, 1'b1);
    a = v[0];
    add_op(v[1], 0);
    add_op(v[2], c);
    a = a & v[3];
    add_op(v[5], 0);
    add_op(v[6], c);
    a = a & 8'h21;
    add_op(v[7], 0);
    c = a >> 7;
    a = (a << 1) & 255;
    z = (a == 0);
    bus(REG_ACC, 1'b0, 32'h0);
    chk_w(rd & 32'hFF, 32'(a));
    chk_w(rd >> 8, {30'h0, z, c[0]});
    repeat (20) @(posedge ref_clk);
    chk_b(core_gated, 1'b1);
    bus(REG_PC, 1'b0, 32'h0);
    chk_w(rd, 32'h0000_0114);
    // Wake pulse from the partner, then the debug halt
    @(posedge ref_clk);
    fire_wake <= 1'b1;
    @(posedge ref_clk);
    fire_wake <= 1'b0;
    wait_pin(0, 1'b0);
    chk_b(core_gated, 1'b0);
    wait_pin(1, 1'b1);
    chk_b(in_bdm, 1'b1);
    bus(REG_ACC, 1'b0, 32'h0);
    chk_w({24'h0, rd[7:0]}, {24'h0, v[4]});
    bus(REG_EVT, 1'b0, 32'h0);
    chk_w({31'h0, rd[0]}, 32'h1);
    bus(REG_EVT, 1'b1, 32'h1);
    bus(REG_EVT, 1'b0, 32'h0);
    chk_w({31'h0, rd[0]}, 32'h0);
    // Reset after the one-cycle halt (core has left it), then request debug before running
    do_reset();
    chk_b(in_bdm, 1'b0);
    bus(REG_PC, 1'b0, 32'h0);
    chk_w(rd, {18'h0, RESET_PC});
    @(posedge ref_clk);
    dbg_on <= 1'b1;
    repeat (4) bus(REG_STAT, 1'b0, 32'h0);
    bus(REG_CTRL, 1'b1, 32'h1);
    wait_pin(1, 1'b1);
    chk_b(in_bdm, 1'b1);
    bus(REG_PC, 1'b0, 32'h0);
    chk_w(rd, {18'h0, RESET_PC});
    // Status word: no wake since reset, halted state, halt flag up
    bus(REG_STAT, 1'b0, 32'h0);
    chk_w(rd, {27'h0, 1'b0, TCDL_BDM, 1'b1});
    close_out();
  end
endmodule : tb
